// ### rtl/tft_tlb.sv
/*
 Translation cache with 32-bit paged table walker and translation fence handling.
 Assumes a pipeline that issues one lookup at a time and a memory read port for tables.
*/
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tft_tlb (
	input  wire logic                         clock,
	input  wire logic                         nrst,
	input  wire logic [3:0]                   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output var  logic                         s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output var  logic                         s_axi_wready,
	output var  logic [1:0]                   s_axi_bresp,
	output var  logic                         s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [3:0]                   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output var  logic                         s_axi_arready,
	output var  logic [31:0]                  s_axi_rdata,
	output var  logic [1:0]                   s_axi_rresp,
	output var  logic                         s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	input  wire logic                         req_valid,
	input  wire tft_pkg::tft_req_t            req,
	output var  logic                         req_ready,
	output var  logic                         resp_valid,
	output tft_pkg::tft_resp_t                resp,
	output var  logic                         mem_req_valid,
	output var  logic [tft_pkg::PADDR_W-1:0]  mem_req_addr,
	input  wire logic                         mem_req_ready,
	input  wire logic                         mem_rsp_valid,
	input  wire logic [31:0]                  mem_rsp_data,
	input  wire logic                         fence_valid,
	input  wire tft_pkg::tft_fence_t          fence,
	output var  logic                         fence_done,
	output var  logic                         fence_illegal
);
	import tft_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE, ST_LOOKUP, ST_L1_REQ, ST_L1_WAIT, ST_L0_REQ, ST_L0_WAIT
	} tft_state_t;

	tft_state_t                       state;
	tft_state_t                       next_state;
	tft_ctrl_t                        ctrl;
	tft_req_t                         cur;
	tft_entry_t                       tlb [TLB_ENTRIES];
	tft_entry_t                       hit_entry;
	tft_entry_t                       fill_entry;
	logic [TLB_ENTRIES-1:0]           hit_vec;
	logic [TLB_ENTRIES-1:0]           kill_vec;
	logic                             hit;
	logic [TLB_IDX_W-1:0]             victim;
	logic [TLB_IDX_W:0]               valid_count;
	logic [PPN_W-1:0]                 next_ppn;
	logic                             fill;
	logic                             walk_fault;
	logic                             fence_take;
	logic [IMPLEMENTED_TAG_WIDTH-1:0] fence_tag;
	logic [31:0]                      pte;

	tft_regs u_regs (
		.clock         (clock),
		.nrst          (nrst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.valid_count   (valid_count),
		.walk_busy     (state != ST_IDLE),
		.ctrl          (ctrl)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers
	function automatic logic vpn_match(input tft_entry_t e, input logic [31:0] va);
		return e.superpage ? (e.vpn[VPN_W-1:10] == va[31:22]) : (e.vpn == va[31:12]);
	endfunction

	function automatic logic perm_ok(input tft_entry_t e, input tft_req_t r,
			input tft_ctrl_t c);
		logic priv_ok;
		priv_ok = r.user ? e.u : (!e.u || c.supervisor_user_access);
		case (r.access)
			ACC_FETCH: return e.x && (r.user ? e.u : !e.u);
			ACC_STORE: return e.w && priv_ok;
			default: return (e.r || (c.exec_readable_enable && e.x)) && priv_ok;
		endcase
	endfunction

	function automatic logic [PADDR_W-1:0] phys(input tft_entry_t e, input logic [31:0] va);
		return e.superpage ? {e.ppn[PPN_W-1:10], va[21:0]} : {e.ppn, va[11:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Lookup and fence match, one per entry
	// Tag operand cut to implemented width, upper bits unused
	assign fence_tag = fence.tag_value[IMPLEMENTED_TAG_WIDTH-1:0];
	assign fence_take = fence_valid && state == ST_IDLE;

	genvar gi;
	generate
		for (gi = 0; gi < TLB_ENTRIES; gi++) begin : g_match
			// Global entries match every tag in use
			assign hit_vec[gi] = tlb[gi].valid && vpn_match(tlb[gi], cur.vaddr)
				&& (tlb[gi].global_map || tlb[gi].tag == ctrl.tag);
			// Leaf-only cache, so address fences cover non-leaf changes too
			assign kill_vec[gi] = (!fence.addr_nonzero || vpn_match(tlb[gi], fence.vaddr))
				&& (!fence.tag_nonzero || (!tlb[gi].global_map && tlb[gi].tag == fence_tag));
		end
	endgenerate

	// Lowest matching entry wins when several match
	always_comb begin
		hit = 1'b0;
		hit_entry = tlb[0];
		valid_count = '0;
		for (int i = TLB_ENTRIES - 1; i >= 0; i--) begin
			if (hit_vec[i]) begin
				hit = 1'b1;
				hit_entry = tlb[i];
			end
		end
		for (int i = 0; i < TLB_ENTRIES; i++) begin
			valid_count = valid_count + {{TLB_IDX_W{1'b0}}, tlb[i].valid};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Walk decode of a returned table entry
	assign pte = mem_rsp_data;
	assign next_ppn = pte[PTE_PPN_LSB +: PPN_W];

	always_comb begin
		fill = 1'b0;
		walk_fault = 1'b0;
		fill_entry.valid = 1'b1;
		fill_entry.vpn = cur.vaddr[31:12];
		fill_entry.ppn = next_ppn;
		fill_entry.tag = ctrl.tag;
		fill_entry.global_map = pte[PTE_G];
		fill_entry.superpage = (state == ST_L1_WAIT);
		fill_entry.r = pte[PTE_R];
		fill_entry.w = pte[PTE_W];
		fill_entry.x = pte[PTE_X];
		fill_entry.u = pte[PTE_U];
		if (mem_rsp_valid && (state == ST_L1_WAIT || state == ST_L0_WAIT)) begin
			// Invalid entries are not cached and end the walk
			if (!pte[PTE_V] || (!pte[PTE_R] && pte[PTE_W])) begin
				walk_fault = 1'b1;
			end else if (pte[PTE_R] || pte[PTE_X]) begin
				if (state == ST_L1_WAIT && next_ppn[9:0] != 10'h000) begin
					walk_fault = 1'b1;
				end else begin
					fill = 1'b1;
				end
			end else if (state == ST_L0_WAIT) begin
				walk_fault = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Walker state machine
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (!fence_valid && req_valid && req_ready) begin
					next_state = ST_LOOKUP;
				end
			end
			ST_LOOKUP: begin
				if (ctrl.paged && !hit) begin
					next_state = ST_L1_REQ;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_L1_REQ: begin
				if (mem_req_valid && mem_req_ready) begin
					next_state = ST_L1_WAIT;
				end
			end
			ST_L1_WAIT: begin
				if (fill) begin
					next_state = ST_LOOKUP;
				end else if (walk_fault) begin
					next_state = ST_IDLE;
				end else if (mem_rsp_valid) begin
					next_state = ST_L0_REQ;
				end
			end
			ST_L0_REQ: begin
				if (mem_req_valid && mem_req_ready) begin
					next_state = ST_L0_WAIT;
				end
			end
			ST_L0_WAIT: begin
				if (fill) begin
					next_state = ST_LOOKUP;
				end else if (walk_fault) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			req_ready <= 1'b1;
		end else begin
			state <= next_state;
			req_ready <= (next_state == ST_IDLE);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cur <= '0;
		end else if (state == ST_IDLE && !fence_valid && req_valid && req_ready) begin
			cur <= req;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Table memory requests
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mem_req_valid <= 1'b0;
			mem_req_addr <= '0;
		end else if (mem_req_valid && mem_req_ready) begin
			mem_req_valid <= 1'b0;
		end else if (state == ST_LOOKUP && ctrl.paged && !hit) begin
			// First read from the root pointer only
			mem_req_valid <= 1'b1;
			mem_req_addr <= {ctrl.root, cur.vaddr[31:22], 2'b00};
		end else if (state == ST_L1_WAIT && mem_rsp_valid && !fill && !walk_fault) begin
			// Next level only through a valid pointer entry
			mem_req_valid <= 1'b1;
			mem_req_addr <= {next_ppn, cur.vaddr[21:12], 2'b00};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lookup answers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			resp_valid <= 1'b0;
			resp <= '0;
		end else begin
			resp_valid <= 1'b0;
			if (state == ST_LOOKUP && !ctrl.paged) begin
				// Untranslated answer follows the mode bit at once
				resp_valid <= 1'b1;
				resp <= '{paddr: {2'b00, cur.vaddr}, fault: 1'b0, abort: 1'b0};
			end else if (state == ST_LOOKUP && hit) begin
				// Permissions use the live privilege control bits
				resp_valid <= 1'b1;
				resp.paddr <= phys(hit_entry, cur.vaddr);
				resp.fault <= !perm_ok(hit_entry, cur, ctrl) && !cur.speculative;
				resp.abort <= !perm_ok(hit_entry, cur, ctrl) && cur.speculative;
			end else if (walk_fault) begin
				resp_valid <= 1'b1;
				resp.paddr <= '0;
				resp.fault <= !cur.speculative;
				resp.abort <= cur.speculative;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Entry storage, fill and fence invalidation
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < TLB_ENTRIES; i++) begin
				tlb[i] <= '0;
			end
			victim <= '0;
		end else if (fence_take && PAGING_SUPPORTED) begin
			// Every 32-bit address is valid here, so each fence acts
			for (int i = 0; i < TLB_ENTRIES; i++) begin
				if (kill_vec[i]) begin
					tlb[i].valid <= 1'b0;
				end
			end
		end else if (fill) begin
			tlb[victim] <= fill_entry;
			victim <= victim + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fence_done <= 1'b0;
			fence_illegal <= 1'b0;
		end else begin
			fence_done <= fence_take;
			fence_illegal <= fence_take && !PAGING_SUPPORTED;
		end
	end

endmodule
`default_nettype wire

// ### rtl/tft_pkg.sv
/*
 Shared constants, register map and carrier types of the translation fence TLB.
 Assumes a 32-bit supervisor width and one hart per block instance.
*/
package tft_pkg;

	localparam int SUPERVISOR_REG_WIDTH = 32;
	localparam int MAX_TAG_WIDTH        = 9;
	localparam int IMPLEMENTED_TAG_WIDTH = 4;
	localparam int TLB_ENTRIES          = 8;
	localparam int TLB_IDX_W            = 3;
	localparam int PPN_W                = 22;
	localparam int VPN_W                = 20;
	localparam int PADDR_W              = 34;

	// Paging hardware present; zero makes the mode field read-only zero
	localparam logic PAGING_SUPPORTED = 1'b1;

	// Register byte offsets
	localparam logic [3:0] ADDR_XLATE_CTRL = 4'h0;
	localparam logic [3:0] ADDR_PRIV_CTRL  = 4'h4;
	localparam logic [3:0] ADDR_STATUS     = 4'h8;
	localparam logic [3:0] ADDR_CONFIG     = 4'hC;

	// Translation control fields
	localparam int XC_MODE_BIT = 31;
	localparam int XC_TAG_LSB  = 22;
	localparam int XC_PPN_LSB  = 0;
	localparam logic [31:0] XLATE_CTRL_RESET = 32'h0000_0000;

	// Privilege control fields
	localparam int PC_SUPERVISOR_USER_ACCESS = 0;
	localparam int PC_EXEC_READABLE_ENABLE   = 1;
	localparam logic [1:0] PRIV_CTRL_RESET   = 2'h0;

	// Status fields
	localparam int ST_COUNT_LSB = 0;
	localparam int ST_BUSY_BIT  = 8;

	// Page table entry fields
	localparam int PTE_V   = 0;
	localparam int PTE_R   = 1;
	localparam int PTE_W   = 2;
	localparam int PTE_X   = 3;
	localparam int PTE_U   = 4;
	localparam int PTE_G   = 5;
	localparam int PTE_PPN_LSB = 10;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_DECERR = 2'h3;

	typedef enum logic [1:0] {ACC_LOAD, ACC_STORE, ACC_FETCH} tft_access_t;

	typedef struct packed {
		logic                             valid;
		logic [VPN_W-1:0]                 vpn;
		logic [PPN_W-1:0]                 ppn;
		logic [IMPLEMENTED_TAG_WIDTH-1:0] tag;
		logic                             global_map;
		logic                             superpage;
		logic                             r;
		logic                             w;
		logic                             x;
		logic                             u;
	} tft_entry_t;

	typedef struct packed {
		logic                             paged;
		logic [IMPLEMENTED_TAG_WIDTH-1:0] tag;
		logic [PPN_W-1:0]                 root;
		logic                             supervisor_user_access;
		logic                             exec_readable_enable;
	} tft_ctrl_t;

	typedef struct packed {
		logic [31:0] vaddr;
		tft_access_t access;
		logic        user;
		logic        speculative;
	} tft_req_t;

	typedef struct packed {
		logic [PADDR_W-1:0] paddr;
		logic               fault;
		logic               abort;
	} tft_resp_t;

	typedef struct packed {
		logic        addr_nonzero;
		logic        tag_nonzero;
		logic [31:0] vaddr;
		logic [31:0] tag_value;
	} tft_fence_t;

endpackage

// ### rtl/tft_regs.sv
/*
 AXI4-Lite register slave holding translation and privilege control.
 Assumes one outstanding write and one outstanding read from the master.
*/
`timescale 1ns/1ps
`default_nettype none
module tft_regs (
	input  wire logic                 clock,
	input  wire logic                 nrst,
	input  wire logic [3:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output var  logic                 s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output var  logic                 s_axi_wready,
	output var  logic [1:0]           s_axi_bresp,
	output var  logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [3:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output var  logic                 s_axi_arready,
	output var  logic [31:0]          s_axi_rdata,
	output var  logic [1:0]           s_axi_rresp,
	output var  logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic [tft_pkg::TLB_IDX_W:0] valid_count,
	input  wire logic                 walk_busy,
	output tft_pkg::tft_ctrl_t        ctrl
);
	import tft_pkg::*;

	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic [31:0] xlate_ctrl;
	logic [1:0]  priv_ctrl;
	logic        do_write;
	logic [31:0] next_xlate;
	logic [31:0] tag_mask;
	logic [31:0] priv_merged;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Tag bits above the implemented width are not stored
	assign tag_mask = {{(32-XC_TAG_LSB-IMPLEMENTED_TAG_WIDTH){1'b0}},
		{IMPLEMENTED_TAG_WIDTH{1'b1}}, {XC_TAG_LSB{1'b0}}} | {{10{1'b0}}, {PPN_W{1'b1}}}
		| ({31'h0000_0000, PAGING_SUPPORTED} << XC_MODE_BIT);
	assign next_xlate = merge(xlate_ctrl, w_data, w_strb) & tag_mask;
	assign priv_merged = merge({30'h0000_0000, priv_ctrl}, w_data, w_strb);
	assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// Controls act on the next lookup with no fence needed
	assign ctrl.paged = xlate_ctrl[XC_MODE_BIT];
	assign ctrl.tag = xlate_ctrl[XC_TAG_LSB +: IMPLEMENTED_TAG_WIDTH];
	assign ctrl.root = xlate_ctrl[XC_PPN_LSB +: PPN_W];
	assign ctrl.supervisor_user_access = priv_ctrl[PC_SUPERVISOR_USER_ACCESS];
	assign ctrl.exec_readable_enable = priv_ctrl[PC_EXEC_READABLE_ENABLE];

	////////////////////////////////////////////////////////////////////////////////
	// Write channels
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == ADDR_XLATE_CTRL || aw_addr == ADDR_PRIV_CTRL ||
					aw_addr == ADDR_STATUS || aw_addr == ADDR_CONFIG) ? AXI_OKAY : AXI_DECERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			xlate_ctrl <= XLATE_CTRL_RESET;
			priv_ctrl <= PRIV_CTRL_RESET;
		end else if (do_write) begin
			if (aw_addr == ADDR_XLATE_CTRL) begin
				xlate_ctrl <= next_xlate;
			end
			if (aw_addr == ADDR_PRIV_CTRL) begin
				priv_ctrl <= priv_merged[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channels
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= AXI_OKAY;
			case (s_axi_araddr)
				ADDR_XLATE_CTRL: s_axi_rdata <= xlate_ctrl;
				ADDR_PRIV_CTRL: s_axi_rdata <= {30'h0000_0000, priv_ctrl};
				ADDR_STATUS: s_axi_rdata <= {23'h00_0000, walk_busy, 4'h0, valid_count};
				ADDR_CONFIG: s_axi_rdata <= 32'(IMPLEMENTED_TAG_WIDTH);
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= AXI_DECERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// ### testbench/tft_tlb_monitor.sv
/*
 Port checker of the translation fence TLB.
 Assumes a bind onto tft_tlb from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module tft_tlb_monitor (
	input wire logic                  clock,
	input wire logic                  nrst,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  req_valid,
	input wire tft_pkg::tft_req_t     req,
	input wire logic                  req_ready,
	input wire logic                  resp_valid,
	input wire tft_pkg::tft_resp_t    resp,
	input wire logic                  mem_req_valid,
	input wire logic                  mem_req_ready,
	input wire logic [33:0]           mem_req_addr,
	input wire logic                  fence_valid,
	input wire logic                  fence_done,
	input wire logic                  fence_illegal
);
	import tft_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	logic spec;
	wire  take = req_valid & req_ready & !fence_valid;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			spec <= 1'b0;
		else if (take)
			spec <= req.speculative;
	end
	AST_SPEC: assert property (resp_valid && spec |-> !resp.fault)
		else $error("fault on speculative lookup");
	AST_FENCE: assert property (fence_valid && req_ready |=> fence_done)
		else $error("fence not done");
	AST_ILLEGAL: assert property (!fence_illegal)
		else $error("fence refused");
	AST_WALK_HOLD: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req_addr))
		else $error("table read dropped");
	AST_ANSWER: assert property (take |-> ##[2:400] resp_valid)
		else $error("lookup unanswered");
	AST_BUSY: assert property (take |=> !req_ready until resp_valid)
		else $error("second lookup taken");
	AST_PULSE: assert property (resp_valid |=> !resp_valid)
		else $error("answer too long");
	AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
endmodule
`default_nettype wire

// ### testbench/tft_mem_model.sv
/*
 Page table memory of the hart, answering table reads.
 Assumes the bench fills pte with whole entries.
*/
`timescale 1ns/1ps
`default_nettype none
module tft_mem_model (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        slow,
	input  wire logic        mem_req_valid,
	input  wire logic [33:0] mem_req_addr,
	output var  logic        mem_req_ready,
	output var  logic        mem_rsp_valid,
	output var  logic [31:0] mem_rsp_data
);
	logic [31:0] pte [logic [33:0]];
	int          stray;
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			mem_req_ready <= 1'b0;
			mem_rsp_valid <= 1'b0;
			mem_rsp_data  <= 32'h0;
			stray         <= 0;
		end else begin
			mem_req_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
			mem_rsp_valid <= mem_req_valid & mem_req_ready;
			if (mem_req_valid & mem_req_ready) begin
				// Only tables reached from root or valid entries
				mem_rsp_data <= pte.exists(mem_req_addr) ? pte[mem_req_addr] : 32'h0;
				if (!pte.exists(mem_req_addr))
					stray <= stray + 1;
			end else
				mem_rsp_data <= ~mem_rsp_data;
		end
	end
endmodule
`default_nettype wire

// ### testbench/translation_fence_tlb_bench.sv
/*
 Bench of the translation fence TLB with reference walker.
 Assumes the monitor and memory model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module translation_fence_tlb_bench;
	import tft_pkg::*;
	logic        clock = 0, nrst = 0, slow = 0, req_valid = 0, fence_valid = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, mem_rsp_data, ctl = 0, pv = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        req_ready, resp_valid, mem_req_valid, mem_req_ready, mem_rsp_valid;
	logic        fence_done, fence_illegal;
	logic [33:0] mem_req_addr;
	tft_req_t    req = '0;
	tft_fence_t  fence = '0;
	tft_resp_t   resp, e;
	int          miscompares = 0, check_count = 0, n;
	logic [7:0]  fl [4] = '{8'hC7, 8'hDF, 8'h49, 8'h63};
	always #10 clock = ~clock;
	tft_tlb dut_u (.*);
	tft_mem_model mem_u (.*);
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cmp(input logic [63:0] g, x);
		check_count++;
		if (g !== x) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic wt(ref logic s);
		n = 0;
		do begin
			@(posedge clock);
			if (n++ > 500) begin
				miscompares++;
				end_of_test();
			end
		end while (s !== 1'b1);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		wt(s_axi_awready);
		s_axi_awvalid <= 1'b0;
		if (!s_axi_wready)
			wt(s_axi_wready);
		s_axi_wvalid <= 1'b0;
		wt(s_axi_bvalid);
		s_axi_bready <= 1'b0;
		cmp(s_axi_bresp, AXI_OKAY);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		wt(s_axi_arready);
		s_axi_arvalid <= 1'b0;
		wt(s_axi_rvalid);
		s_axi_rready <= 1'b0;
		cmp(s_axi_rresp, r);
		if (r == AXI_OKAY)
			cmp(s_axi_rdata, d);
	endtask
	task automatic setc(input logic [31:0] d);
		ctl = d;
		wr(ADDR_XLATE_CTRL, d);
		rd(ADDR_XLATE_CTRL, d, AXI_OKAY);
	endtask
	function automatic tft_resp_t ref_tr(input logic [31:0] v, input tft_access_t ac,
		input logic u, sp);
		logic [31:0] p;
		logic        ok;
		if (!ctl[31])
			return '{{2'h0, v}, 1'b0, 1'b0};
		p = mem_u.pte[{ctl[21:0], v[31:22], 2'h0}];
		if (!p[PTE_V])
			return '{34'h0, !sp, sp};
		p = mem_u.pte[{p[31:10], v[21:12], 2'h0}];
		ok = p[PTE_V] & !(p[PTE_W] & !p[PTE_R]);
		ok &= u ? p[PTE_U] : (!p[PTE_U] | (pv[0] & ac != ACC_FETCH));
		case (ac)
			ACC_FETCH: ok &= p[PTE_X];
			ACC_LOAD:  ok &= p[PTE_R] | (pv[1] & p[PTE_X]);
			default:   ok &= p[PTE_W];
		endcase
		return '{{p[31:10], v[11:0]}, !ok & !sp, !ok & sp};
	endfunction
	task automatic look(input logic [31:0] v, input tft_access_t ac, input logic u, sp, k);
		if (!k)
			e = ref_tr(v, ac, u, sp);
		req <= '{v, ac, u, sp};
		req_valid <= 1'b1;
		wt(req_ready);
		req_valid <= 1'b0;
		wt(resp_valid);
		if (e.fault | e.abort)
			cmp(resp[1:0], e[1:0]);
		else
			cmp(resp, e);
	endtask
	task automatic fen(input logic an, tn, input logic [31:0] v, t);
		fence <= '{an, tn, v, t};
		fence_valid <= 1'b1;
		wt(req_ready);
		fence_valid <= 1'b0;
		wt(fence_done);
	endtask
	function automatic logic [31:0] va(input int k);
		return 32'h00400ABC | 32'(k << 12);
	endfunction
	function automatic logic [33:0] pa(input int k);
		return {22'h101, 10'(k), 2'h0};
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h221AE86B));
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		rd(ADDR_CONFIG, 32'(IMPLEMENTED_TAG_WIDTH), AXI_OKAY);
		rd(4'h2, 32'h0, AXI_DECERR);
		for (int i = 0; i < 4; i++)
			look($urandom, tft_access_t'(i % 3), i[0], 1'b0, 1'b0);
		mem_u.pte[{22'h100, 10'h1, 2'h0}] = {22'h101, 10'h1};
		for (int k = 0; k < 4; k++)
			mem_u.pte[pa(k)] = {22'h200 + 22'(k), 2'h0, fl[k]};
		slow = 1'b1;
		setc({1'b1, 5'h0, 4'h3, 22'h100});
		mem_u.pte[{22'h100, 10'h2, 2'h0}] = 32'h0;
		look(32'h00800123, ACC_LOAD, 1'b0, 1'b0, 1'b0);
		for (int k = 0; k < 12; k++)
			look(va(k / 3), tft_access_t'(k % 3), 1'b0, k / 3 == 1, 1'b0);
		look(va(1), ACC_LOAD, 1'b1, 1'b0, 1'b0);
		pv = 3;
		wr(ADDR_PRIV_CTRL, pv);
		for (int k = 0; k < 3; k++)
			look(va(k % 2 + 1), tft_access_t'(k / 2 * 2), 1'b0, 1'b0, 1'b0);
		e = ref_tr(va(0), ACC_LOAD, 1'b0, 1'b0);
		mem_u.pte[pa(0)] = {22'h2F0, 2'h0, fl[0]};
		look(va(0), ACC_LOAD, 1'b0, 1'b0, 1'b1);
		fen(1'b1, 1'b1, va(0), 32'hFFFFFFF3);
		look(va(0), ACC_LOAD, 1'b0, 1'b0, 1'b0);
		mem_u.pte[pa(0)] = {22'h2F1, 2'h0, fl[0]};
		setc({1'b1, 5'h0, 4'h5, 22'h100});
		look(va(0), ACC_LOAD, 1'b0, 1'b0, 1'b0);
		setc(32'h0);
		look(va(2), ACC_STORE, 1'b0, 1'b0, 1'b0);
		setc({1'b1, 5'h0, 4'h5, 22'h100});
		fen(1'b0, 1'b1, 32'h0, 32'h0);
		e = ref_tr(va(3), ACC_LOAD, 1'b0, 1'b0);
		mem_u.pte[pa(3)] = {22'h2E3, 2'h0, fl[3]};
		fen(1'b0, 1'b1, 32'h0, 32'h5);
		look(va(3), ACC_LOAD, 1'b0, 1'b0, 1'b1);
		fen(1'b0, 1'b0, 32'h0, 32'h0);
		look(va(3), ACC_LOAD, 1'b0, 1'b0, 1'b0);
		cmp(mem_u.stray, 0);
		end_of_test();
	end
endmodule
bind tft_tlb tft_tlb_monitor mon_u (.*);
`default_nettype wire
